// *** hw/dmaec_defs.svh ***
`ifndef DMAEC_DEFS_SVH
`define DMAEC_DEFS_SVH

// Channel, set and region counts
`define DMAEC_NCH        64
`define DMAEC_NQ         8
`define DMAEC_NSET       72
`define DMAEC_NREG       2

// Register byte addresses; 64-bit groups take low word then high word
`define DMAEC_A_EVT      8'h00
`define DMAEC_A_EVT_SET  8'h08
`define DMAEC_A_EVT_CLR  8'h10
`define DMAEC_A_EEN      8'h18
`define DMAEC_A_EEN_SET  8'h20
`define DMAEC_A_EEN_CLR  8'h28
`define DMAEC_A_SEC      8'h30
`define DMAEC_A_MISS     8'h38
`define DMAEC_A_PEND     8'h40
`define DMAEC_A_IEN      8'h48
`define DMAEC_A_IEN_SET  8'h50
`define DMAEC_A_IEN_CLR  8'h58
`define DMAEC_A_RAM0     8'h60
`define DMAEC_A_RAM1     8'h68
`define DMAEC_A_QEV      8'h70
`define DMAEC_A_QEN      8'h74
`define DMAEC_A_QSEC     8'h78
`define DMAEC_A_QMISS    8'h7C
`define DMAEC_A_ERR      8'h80
`define DMAEC_A_EMSK     8'h84
`define DMAEC_A_SIDX     8'h88
`define DMAEC_A_SWORD    8'h8C

// Reset values
`define DMAEC_ZERO64     64'h0000_0000_0000_0000
`define DMAEC_SET_NULL   32'h0000_0000

// Error status bit positions
`define DMAEC_ERR_DMA    0
`define DMAEC_ERR_QUICK_DMA   1

`endif

// *** hw/dmaec_pkg.sv ***
package dmaec_pkg;

   // Transfer set word; all zero is the null set
   typedef struct packed {
      logic [7:0]  count;
      logic [12:0] spare;
      logic [5:0]  code;
      logic        mid_done_irq_on;
      logic        final_done_irq_on;
      logic        link_null;
      logic        is_static;
      logic        valid;
   } dmaec_set_t;

   // Outcome of one service slot
   typedef enum logic [1:0] {
      DMAEC_SV_NONE,
      DMAEC_SV_ERR,
      DMAEC_SV_MID,
      DMAEC_SV_FINAL
   } dmaec_sv_t;

endpackage

// *** hw/dmaec_pick.sv ***
`timescale 1ns/1ns
`include "dmaec_defs.svh"

// Lowest index wins, so DMA channels sit ahead of quick channels
module dmaec_pick (
   input  wire logic [`DMAEC_NSET-1:0] req,
   output logic                        valid,
   output logic [6:0]                  idx
);

   // Scan from the top so the lowest requester is kept last
   always_comb begin
      valid = |req;
      idx   = 7'h00;
      for (int i = `DMAEC_NSET - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 7'(i);
         end
      end
   end

endmodule

// *** hw/dmaec_top.sv ***
`timescale 1ns/1ns
`include "dmaec_defs.svh"

module dmaec_top (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [7:0]            paddr,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [`DMAEC_NCH-1:0] periph_event,
   output logic                       tr_valid,
   output logic [6:0]                 tr_chan,
   output logic [5:0]                 tr_code,
   output logic                       irq_done_global,
   output logic [`DMAEC_NREG-1:0]     irq_done_region,
   output logic                       irq_error
);
   import dmaec_pkg::*;

   logic [63:0]      ev_q, ev_d, een_q, een_d, sec_q, sec_d;
   logic [63:0]      miss_q, miss_d, pend_q, pend_d, ien_q, ien_d;
   logic [63:0]      ram_q [0:`DMAEC_NREG-1];
   logic [63:0]      ram_d [0:`DMAEC_NREG-1];
   logic [7:0]       qev_q, qev_d, qen_q, qen_d;
   logic [7:0]       qsec_q, qsec_d, qmiss_q, qmiss_d;
   logic [1:0]       err_q, err_d, emsk_q, emsk_d;
   logic [6:0]       sidx_q, sidx_d;
   dmaec_set_t       set_q [0:`DMAEC_NSET-1];
   dmaec_set_t       set_d [0:`DMAEC_NSET-1];
   logic [31:0]      prdata_q, prdata_d;
   logic             slverr_q, slverr_d;
   logic             trv_q, trv_d;
   logic [6:0]       trc_q, trc_d;
   logic [5:0]       trk_q, trk_d;
   logic             wr, setup, hi, rd_hit;
   logic [31:0]      rd_val;
   logic [`DMAEC_NSET-1:0] cand;
   logic             pk_valid;
   logic [6:0]       pk_idx;
   logic             pk_quick;
   dmaec_set_t       cur;
   dmaec_sv_t        sv;
   logic             irq_hit, nulling;
   logic             sw_set_wr;

   // Word-wide write into one half of a 64-bit group
   function automatic logic [63:0] dmaec_wm(input logic [7:0] a,
                                            input logic [7:0] base,
                                            input logic w,
                                            input logic [31:0] d);
      logic [63:0] r;
      r = 64'h0000_0000_0000_0000;
      // Misaligned address is refused, so it must not write either
      if (w && a[1:0] == 2'b00 && a[7:3] == base[7:3]) begin
         r = a[2] ? {d, 32'h0000_0000} : {32'h0000_0000, d};
      end
      return r;
   endfunction

   // One 32-bit half of a 64-bit group
   function automatic logic [31:0] dmaec_half(input logic [63:0] v,
                                              input logic h);
      return h ? v[63:32] : v[31:0];
   endfunction

   assign wr    = psel & penable & pwrite;
   assign setup = psel & ~penable;
   assign hi    = paddr[2];
   assign sw_set_wr = wr && paddr == `DMAEC_A_SWORD;

   // Candidates: enabled, latched, not blocked by a secondary flag
   assign cand = {qev_q & qen_q & ~qsec_q,
                  ev_q & een_q & ~sec_q};

   dmaec_pick u_pick (
      .req   (cand),
      .valid (pk_valid),
      .idx   (pk_idx)
   );

   assign pk_quick = pk_idx[6];

   // Service outcome for the picked channel
   always_comb begin
      cur     = set_q[pk_idx];
      sv      = DMAEC_SV_NONE;
      if (pk_valid) begin
         if (!cur.valid) begin
            sv = DMAEC_SV_ERR;
         end else if (cur.count <= 8'h01) begin
            sv = DMAEC_SV_FINAL;
         end else begin
            sv = DMAEC_SV_MID;
         end
      end
      irq_hit = (sv == DMAEC_SV_FINAL && cur.final_done_irq_on) ||
                (sv == DMAEC_SV_MID && cur.mid_done_irq_on);
      nulling = sv == DMAEC_SV_FINAL && !cur.is_static &&
                cur.link_null;
   end

   // Transfer set memory next state; software write lands last
   always_comb begin
      set_d = set_q;
      if (sv == DMAEC_SV_MID && !cur.is_static) begin
         set_d[pk_idx].count = cur.count - 8'h01;
      end
      if (nulling) begin
         set_d[pk_idx] = dmaec_set_t'(`DMAEC_SET_NULL);
      end
      if (sw_set_wr && sidx_q < 7'(`DMAEC_NSET)) begin
         set_d[sidx_q] = dmaec_set_t'(pwdata);
      end
   end

   // DMA event, enable, secondary and miss flags; sets beat clears, except on enable where clears win
   always_comb begin
      ev_d = ev_q & ~dmaec_wm(paddr, `DMAEC_A_EVT_CLR, wr, pwdata);
      if (sv != DMAEC_SV_NONE && !pk_quick) begin
         ev_d[pk_idx[5:0]] = 1'b0;
      end
      ev_d = ev_d | periph_event |
             dmaec_wm(paddr, `DMAEC_A_EVT_SET, wr, pwdata);
      een_d = (een_q | dmaec_wm(paddr, `DMAEC_A_EEN_SET, wr, pwdata)) &
              ~dmaec_wm(paddr, `DMAEC_A_EEN_CLR, wr, pwdata);
      sec_d  = sec_q & ~dmaec_wm(paddr, `DMAEC_A_SEC, wr, pwdata);
      miss_d = (miss_q & ~dmaec_wm(paddr, `DMAEC_A_MISS, wr, pwdata)) |
               (periph_event & ev_q);
      if (sv == DMAEC_SV_ERR && !pk_quick) begin
         sec_d[pk_idx[5:0]]  = 1'b1;
         miss_d[pk_idx[5:0]] = 1'b1;
      end
   end

   // Quick channel event, enable and flags
   always_comb begin
      qev_d   = qev_q;
      qsec_d  = qsec_q & ~pwdata[7:0];
      qmiss_d = qmiss_q & ~pwdata[7:0];
      if (!(wr && paddr == `DMAEC_A_QSEC)) begin
         qsec_d = qsec_q;
      end
      if (!(wr && paddr == `DMAEC_A_QMISS)) begin
         qmiss_d = qmiss_q;
      end
      qen_d = (wr && paddr == `DMAEC_A_QEN) ? pwdata[7:0] : qen_q;
      if (sv != DMAEC_SV_NONE && pk_quick) begin
         qev_d[pk_idx[2:0]] = 1'b0;
      end
      if (sv == DMAEC_SV_ERR && pk_quick) begin
         qsec_d[pk_idx[2:0]]  = 1'b1;
         qmiss_d[pk_idx[2:0]] = 1'b1;
      end
      // Nulling or a software write of a quick channel's set retriggers it
      if (nulling && pk_quick) begin
         qev_d[pk_idx[2:0]] = 1'b1;
      end
      if (sw_set_wr && sidx_q[6] && sidx_q < 7'(`DMAEC_NSET)) begin
         qev_d[sidx_q[2:0]] = 1'b1;
      end
   end

   // Completion pending, enables, region masks, error status
   always_comb begin
      pend_d = pend_q & ~dmaec_wm(paddr, `DMAEC_A_PEND, wr, pwdata);
      if (irq_hit) begin
         pend_d[cur.code] = 1'b1;
      end
      ien_d = (ien_q | dmaec_wm(paddr, `DMAEC_A_IEN_SET, wr, pwdata)) &
              ~dmaec_wm(paddr, `DMAEC_A_IEN_CLR, wr, pwdata);
      for (int r = 0; r < `DMAEC_NREG; r++) begin
         ram_d[r] = ram_q[r];
      end
      ram_d[0] = (ram_q[0] &
                  ~dmaec_wm(paddr, `DMAEC_A_RAM0, wr, 32'hFFFF_FFFF)) |
                 dmaec_wm(paddr, `DMAEC_A_RAM0, wr, pwdata);
      ram_d[1] = (ram_q[1] &
                  ~dmaec_wm(paddr, `DMAEC_A_RAM1, wr, 32'hFFFF_FFFF)) |
                 dmaec_wm(paddr, `DMAEC_A_RAM1, wr, pwdata);
      err_d = err_q;
      if (wr && paddr == `DMAEC_A_ERR) begin
         err_d = err_q & ~pwdata[1:0];
      end
      if (sv == DMAEC_SV_ERR) begin
         err_d[pk_quick ? `DMAEC_ERR_QUICK_DMA : `DMAEC_ERR_DMA] = 1'b1;
      end
      emsk_d = (wr && paddr == `DMAEC_A_EMSK) ? pwdata[1:0] : emsk_q;
      sidx_d = (wr && paddr == `DMAEC_A_SIDX) ? pwdata[6:0] : sidx_q;
      trv_d  = sv == DMAEC_SV_MID || sv == DMAEC_SV_FINAL;
      trc_d  = trv_d ? pk_idx : trc_q;
      trk_d  = trv_d ? cur.code : trk_q;
   end

   // Read mux; write-only ports read as zero
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      case (paddr)
         `DMAEC_A_EVT, `DMAEC_A_EVT + 8'h04:   rd_val = dmaec_half(ev_q, hi);
         `DMAEC_A_EEN, `DMAEC_A_EEN + 8'h04:   rd_val = dmaec_half(een_q, hi);
         `DMAEC_A_SEC, `DMAEC_A_SEC + 8'h04:   rd_val = dmaec_half(sec_q, hi);
         `DMAEC_A_MISS, `DMAEC_A_MISS + 8'h04: rd_val = dmaec_half(miss_q, hi);
         `DMAEC_A_PEND, `DMAEC_A_PEND + 8'h04: rd_val = dmaec_half(pend_q, hi);
         `DMAEC_A_IEN, `DMAEC_A_IEN + 8'h04:   rd_val = dmaec_half(ien_q, hi);
         `DMAEC_A_RAM0, `DMAEC_A_RAM0 + 8'h04:
            rd_val = dmaec_half(ram_q[0], hi);
         `DMAEC_A_RAM1, `DMAEC_A_RAM1 + 8'h04:
            rd_val = dmaec_half(ram_q[1], hi);
         `DMAEC_A_EVT_SET, `DMAEC_A_EVT_SET + 8'h04,
         `DMAEC_A_EVT_CLR, `DMAEC_A_EVT_CLR + 8'h04,
         `DMAEC_A_EEN_SET, `DMAEC_A_EEN_SET + 8'h04,
         `DMAEC_A_EEN_CLR, `DMAEC_A_EEN_CLR + 8'h04,
         `DMAEC_A_IEN_SET, `DMAEC_A_IEN_SET + 8'h04,
         `DMAEC_A_IEN_CLR, `DMAEC_A_IEN_CLR + 8'h04:
            rd_val = 32'h0000_0000;
         `DMAEC_A_QEV:   rd_val = {24'h00_0000, qev_q};
         `DMAEC_A_QEN:   rd_val = {24'h00_0000, qen_q};
         `DMAEC_A_QSEC:  rd_val = {24'h00_0000, qsec_q};
         `DMAEC_A_QMISS: rd_val = {24'h00_0000, qmiss_q};
         `DMAEC_A_ERR:   rd_val = {30'h0000_0000, err_q};
         `DMAEC_A_EMSK:  rd_val = {30'h0000_0000, emsk_q};
         `DMAEC_A_SIDX:  rd_val = {25'h000_0000, sidx_q};
         `DMAEC_A_SWORD:
            rd_val = (sidx_q < 7'(`DMAEC_NSET)) ? 32'(set_q[sidx_q])
                                                 : 32'h0000_0000;
         default:        rd_hit = 1'b0;
      endcase
      // Read data and error are caught in setup so the access cycle
      // answers at once; state moving in that one cycle is not seen
      prdata_d = setup ? rd_val : prdata_q;
      slverr_d = setup ? ~rd_hit : slverr_q;
   end

   // All state registers; reset to constants only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_q     <= `DMAEC_ZERO64;
         een_q    <= `DMAEC_ZERO64;
         sec_q    <= `DMAEC_ZERO64;
         miss_q   <= `DMAEC_ZERO64;
         pend_q   <= `DMAEC_ZERO64;
         ien_q    <= `DMAEC_ZERO64;
         for (int r = 0; r < `DMAEC_NREG; r++) begin
            ram_q[r] <= `DMAEC_ZERO64;
         end
         for (int s = 0; s < `DMAEC_NSET; s++) begin
            set_q[s] <= dmaec_set_t'(`DMAEC_SET_NULL);
         end
         qev_q    <= 8'h00;
         qen_q    <= 8'h00;
         qsec_q   <= 8'h00;
         qmiss_q  <= 8'h00;
         err_q    <= 2'b00;
         emsk_q   <= 2'b00;
         sidx_q   <= 7'h00;
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
         trv_q    <= 1'b0;
         trc_q    <= 7'h00;
         trk_q    <= 6'h00;
      end else begin
         ev_q     <= ev_d;
         een_q    <= een_d;
         sec_q    <= sec_d;
         miss_q   <= miss_d;
         pend_q   <= pend_d;
         ien_q    <= ien_d;
         ram_q    <= ram_d;
         set_q    <= set_d;
         qev_q    <= qev_d;
         qen_q    <= qen_d;
         qsec_q   <= qsec_d;
         qmiss_q  <= qmiss_d;
         err_q    <= err_d;
         emsk_q   <= emsk_d;
         sidx_q   <= sidx_d;
         prdata_q <= prdata_d;
         slverr_q <= slverr_d;
         trv_q    <= trv_d;
         trc_q    <= trc_d;
         trk_q    <= trk_d;
      end
   end

   // Outputs; interrupts are levels held until software clears
   assign prdata   = prdata_q;
   assign pready   = 1'b1;
   assign pslverr  = slverr_q & psel & penable;
   assign tr_valid = trv_q;
   assign tr_chan  = trc_q;
   assign tr_code  = trk_q;
   assign irq_done_global = |(pend_q & ien_q);
   always_comb begin
      for (int r = 0; r < `DMAEC_NREG; r++) begin
         irq_done_region[r] = |(pend_q & ien_q & ram_q[r]);
      end
   end
   assign irq_error = |(err_q & emsk_q);

endmodule

// *** tb/dmaec_properties.sv ***
`timescale 1ns/1ns
`include "dmaec_defs.svh"

// Pin-level checks on the bus and interrupt outputs
module dmaec_props (
   input wire logic                  pclk,
   input wire logic                  presetn,
   input wire logic [7:0]            paddr,
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic [`DMAEC_NCH-1:0] periph_event,
   input wire logic                  tr_valid,
   input wire logic [6:0]            tr_chan,
   input wire logic [5:0]            tr_code,
   input wire logic                  irq_done_global,
   input wire logic [`DMAEC_NREG-1:0] irq_done_region,
   input wire logic                  irq_error
);
   logic acc_wr;
   logic bad_adr;

   // Only a completed write may change enables or clear pending and error flags
   assign acc_wr = psel && penable && pwrite;
   assign bad_adr = (paddr > 8'h8C) || (paddr[1:0] != 2'h0);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ready_always: assert property (pready)
      else $error("pready low");
   a_err_unmapped: assert property (psel && penable && bad_adr
      |-> pslverr && (pwrite || prdata == 32'h0000_0000))
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (psel && penable && !bad_adr |-> !pslverr)
      else $error("mapped access refused");
   a_err_in_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   a_region_needs_global: assert property (
      irq_done_region != 2'b00 |-> irq_done_global)
      else $error("region irq without global");
   a_irq_rise_cause: assert property (
      $rose(irq_done_global) |-> tr_valid || $past(tr_valid) || $past(acc_wr))
      else $error("irq rose without cause");
   a_irq_fall_cause: assert property (
      $fell(irq_done_global) |-> $past(acc_wr))
      else $error("irq fell without write");
   a_err_fall_cause: assert property (
      $fell(irq_error) |-> $past(acc_wr))
      else $error("error irq fell without write");
endmodule

bind dmaec_top dmaec_props i_dmaec_props (.pclk, .presetn, .paddr, .psel,
   .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .periph_event,
   .tr_valid, .tr_chan, .tr_code, .irq_done_global, .irq_done_region,
   .irq_error);

// *** tb/dmaec_periph.sv ***
`timescale 1ns/1ns
`include "dmaec_defs.svh"

// Peripheral event sources; upper half may carry random noise
module dmaec_periph (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        fire,
   input  wire logic [5:0]  chan,
   input  wire logic [31:0] noise,
   output logic [63:0]      periph_event
);
   // Pulses follow fire and noise cycle by cycle, one cycle late; the bench decides how many a set gets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         periph_event <= `DMAEC_ZERO64;
      end else begin
         periph_event <= {noise, 32'h0000_0000} |
            (fire ? 64'h0000_0000_0000_0001 << chan
                  : `DMAEC_ZERO64);
      end
   end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ns
`include "dmaec_defs.svh"

module testbench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [63:0] periph_event;
   logic        tr_valid;
   logic [6:0]  tr_chan;
   logic [5:0]  tr_code;
   logic        irq_done_global;
   logic [1:0]  irq_done_region;
   logic        irq_error;
   logic        fire = 1'b0;
   logic [5:0]  chan = 6'h00;
   logic [31:0] noise = 32'h0000_0000;
   logic [31:0] rq[$];
   logic [12:0] tq[$];
   integer      err_total = 0;
   integer      checked = 0;
   integer      trn = 0;
   integer      t = 0;
   integer      cyc = 0;
   integer      seed = 32'h6b20_a3ee;

   always #25 pclk = ~pclk;

   dmaec_top i_dmaec_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .periph_event, .tr_valid,
      .tr_chan, .tr_code, .irq_done_global, .irq_done_region, .irq_error);
   dmaec_periph i_dmaec_periph (.pclk, .presetn, .fire, .chan, .noise,
      .periph_event);

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task end_sim;
      if (err_total == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Setup, then access held until pready; one idle cycle after
   task wr(input logic [7:0] a, input logic [31:0] d, input logic w = 1);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] exp);
      rq.push_back(exp);
      wr(a, 32'h0000_0000, 1'b0);
   endtask

   // Count of new transfers since last look; negative skips the check
   task settle(input integer n);
      repeat (8) @(posedge pclk);
      if (n >= 0) begin
         chk(trn, t + n);
      end
      t = trn;
   endtask

   task ev(input logic [5:0] c, input integer n);
      fire <= 1'b1;
      chan <= c;
      @(posedge pclk);
      fire <= 1'b0;
      settle(n);
   endtask

   // Interrupt pins are looked at mid-cycle, once settled
   task irq(input logic [3:0] exp);
      @(negedge pclk);
      chk({irq_error, irq_done_region, irq_done_global}, exp);
      @(posedge pclk);
   endtask

   // Scoreboard: oldest note against each read and each request
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
         chk(prdata, rq.pop_front());
      end
      if (tr_valid === 1'b1) begin
         trn = trn + 1;
         if (tq.size() > 0) begin
            chk({19'h0_0000, tr_chan, tr_code}, {19'h0_0000, tq.pop_front()});
         end
      end
      cyc = cyc + 1;
      if (cyc == 6000) begin
         err_total = err_total + 1;
         end_sim;
      end
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`DMAEC_A_EVT, 32'h0000_0000);
      rd(`DMAEC_A_ERR, 32'h0000_0000);
      rd(8'hF0, 32'h0000_0000);
      // Channel 3: two requests, then the set is null
      wr(`DMAEC_A_SIDX, 32'h0000_0003);
      wr(`DMAEC_A_SWORD, 32'h0200_012D);
      ev(6'h03, 0);
      rd(`DMAEC_A_EVT, 32'h0000_0008);
      tq.push_back({7'h03, 6'h09});
      wr(`DMAEC_A_EEN_SET, 32'h0000_0008);
      settle(1);
      rd(`DMAEC_A_PEND, 32'h0000_0000);
      tq.push_back({7'h03, 6'h09});
      ev(6'h03, 1);
      rd(`DMAEC_A_PEND, 32'h0000_0200);
      irq(4'h0);
      wr(`DMAEC_A_IEN_SET, 32'h0000_0200);
      irq(4'h1);
      wr(`DMAEC_A_RAM0, 32'h0000_0200);
      irq(4'h3);
      wr(`DMAEC_A_RAM1, 32'h0000_0200);
      irq(4'h7);
      wr(`DMAEC_A_IEN_CLR, 32'h0000_0200);
      irq(4'h0);
      wr(`DMAEC_A_PEND, 32'h0000_0200);
      wr(`DMAEC_A_IEN_SET, 32'h0000_0200);
      irq(4'h0);
      ev(6'h03, -1);
      rd(`DMAEC_A_SEC, 32'h0000_0008);
      rd(`DMAEC_A_MISS, 32'h0000_0008);
      rd(`DMAEC_A_ERR, 32'h0000_0001);
      ev(6'h03, 0);
      // Stale latched event would hit the null set again at once
      wr(`DMAEC_A_EVT_CLR, 32'h0000_0008);
      wr(`DMAEC_A_SEC, 32'h0000_0008);
      wr(`DMAEC_A_MISS, 32'h0000_0008);
      rd(`DMAEC_A_SEC, 32'h0000_0000);
      rd(`DMAEC_A_MISS, 32'h0000_0000);
      wr(`DMAEC_A_ERR, 32'h0000_0001);
      // Latch and enables move only through their ports
      wr(`DMAEC_A_EVT_CLR, 32'hFFFF_FFFF);
      rd(`DMAEC_A_EVT, 32'h0000_0000);
      wr(`DMAEC_A_EVT_SET, 32'h0000_0020);
      wr(`DMAEC_A_EVT, 32'h0000_0000);
      rd(`DMAEC_A_EVT, 32'h0000_0020);
      wr(`DMAEC_A_EVT_CLR, 32'h0000_0020);
      rd(`DMAEC_A_EVT, 32'h0000_0000);
      wr(`DMAEC_A_EEN, 32'h0000_0000);
      rd(`DMAEC_A_EEN, 32'h0000_0008);
      wr(`DMAEC_A_EEN_CLR, 32'h0000_0008);
      rd(`DMAEC_A_EEN, 32'h0000_0000);
      // Channel 0 returning code 63
      wr(`DMAEC_A_SIDX, 32'h0000_0000);
      wr(`DMAEC_A_SWORD, 32'h0100_07E9);
      wr(`DMAEC_A_EEN_SET, 32'h0000_0001);
      tq.push_back({7'h00, 6'h3F});
      ev(6'h00, 1);
      rd(`DMAEC_A_PEND + 8'h04, 32'h8000_0000);
      rd(`DMAEC_A_PEND, 32'h0000_0000);
      irq(4'h0);
      wr(`DMAEC_A_PEND + 8'h04, 32'h8000_0000);
      // Channel 1 without completion flags
      wr(`DMAEC_A_SIDX, 32'h0000_0001);
      wr(`DMAEC_A_SWORD, 32'h0100_00E1);
      wr(`DMAEC_A_EEN_SET, 32'h0000_0002);
      tq.push_back({7'h01, 6'h07});
      ev(6'h01, 1);
      rd(`DMAEC_A_PEND, 32'h0000_0000);
      // Quick channel 0 triggers on its own set write
      wr(`DMAEC_A_SIDX, 32'h0000_0040);
      wr(`DMAEC_A_SWORD, 32'h0100_028D);
      settle(0);
      rd(`DMAEC_A_QEV, 32'h0000_0001);
      tq.push_back({7'h40, 6'h14});
      wr(`DMAEC_A_QEN, 32'h0000_0001);
      settle(-1);
      rd(`DMAEC_A_QSEC, 32'h0000_0001);
      rd(`DMAEC_A_QMISS, 32'h0000_0001);
      rd(`DMAEC_A_ERR, 32'h0000_0002);
      wr(`DMAEC_A_EMSK, 32'h0000_0003);
      irq(4'h8);
      wr(`DMAEC_A_ERR, 32'h0000_0002);
      irq(4'h0);
      // Random events on disabled upper channels
      repeat (16) begin
         noise <= $random(seed);
         @(posedge pclk);
      end
      noise <= 32'h0000_0000;
      settle(0);
      end_sim;
   end
endmodule
